// File: usm_pkg.sv
package usm_pkg;
  // --------------------
  // Mode encodings
  // --------------------
  localparam logic [1:0] USM_COMM_MODE_SEL_ASYNC  = 2'h0;
  localparam logic [1:0] USM_COMM_MODE_SEL_SPI    = 2'h3;
  localparam logic [1:0] USM_COMM_MODE_SEL_IR     = 2'h2;
  localparam logic [1:0] USM_LD_OFF       = 2'h0;
  localparam logic [1:0] USM_LD_EXT       = 2'h1;
  localparam logic [1:0] USM_LD_TXCTL     = 2'h2;
  localparam logic [1:0] USM_RXM_NORMAL   = 2'h0;
  localparam logic [1:0] USM_RXM_GENERIC_AUTOBAUD_MODE  = 2'h2;
  localparam logic [1:0] USM_RXM_LIN_AUTOBAUD_MODE  = 2'h3;
  localparam logic [1:0] USM_IRTX_3_16    = 2'h0;
  localparam logic [1:0] USM_IRTX_FIXED   = 2'h1;
  localparam logic [1:0] USM_IRTX_OFF     = 2'h2;
  // --------------------
  // Constants
  // --------------------
  localparam logic [7:0]  USM_SYNC_CHAR    = 8'h55;
  localparam int          USM_BREAK_BITS   = 11;
  localparam int          USM_FRAC_BITS    = 6;      // Count / 64
  localparam logic [15:0] USM_BAUD_MIN     = 16'h0064;
  localparam logic [15:0] USM_BAUD_RESET   = 16'h0400;
  localparam int          USM_OVERSAMPLE   = 16;
  localparam int          USM_IR_NUM       = 3;      // 3/16 pulse
  localparam logic [7:0]  USM_TXPL_RESET   = 8'h00;
  localparam logic [6:0]  USM_RXPL_RESET   = 7'h00;

  typedef enum logic [2:0] {
    USM_TX_IDLE  = 3'b000,
    USM_TX_GUARD = 3'b001,
    USM_TX_START = 3'b010,
    USM_TX_DATA  = 3'b011,
    USM_TX_STOP  = 3'b100
  } usm_tx_state_t;

  typedef enum logic [2:0] {
    USM_RX_IDLE  = 3'b000,
    USM_RX_START = 3'b001,
    USM_RX_DATA  = 3'b010,
    USM_RX_STOP  = 3'b011,
    USM_RX_SYNC  = 3'b100
  } usm_rx_state_t;

  // Configuration bundle
  typedef struct packed {
    logic [1:0] comm_mode_sel;
    logic [1:0] line_driver_mode;
    logic [1:0] receive_mode_sel;
    logic [1:0] ir_tx_mod;
    logic       tx_en;
    logic       rx_en;
    logic       start_detect_enable;
    logic       multiproc_filter_en;
    logic       one_wire;
    logic       double_speed_sel;
    logic       spi_clock_phase_sel;
    logic       spi_bit_order_sel;
    logic       ir_event_sel;
    logic       two_stop;
    logic       nine_bit;
  } usm_cfg_t;

  // Receive status bundle
  typedef struct packed {
    logic [8:0] data;
    logic       frame_err;
    logic       rx_complete_flag;
    logic       start_detect_flag;
    logic       sync_mismatch_flag;
    logic       break_flag;
  } usm_rx_stat_t;
endpackage : usm_pkg

// File: usm_core.sv
`timescale 1ns/10ps
// Functional notes
// - In SPI master mode receive error flags read as zero.
// - SPI phase and bit-order bits act like standalone SPI; no collision or 2x.
// - SPI: transmit pin is data out, receive pin data in, clock pin clock.
// - Line-driver field 1 selects external driver, 2 selects transmit pin control.
// - Direction output rises one baud cycle early, holds through stop bits.
// - Standby start edge wakes oscillator, clock, sets start-detect flag.
// - False start bit without other wake source turns clock off again.
// - Start-frame detection only active in standby sleep.
// - Wake at start edge or frame end per enables; else oscillator only.
// - Oscillator kept running while reception is in progress.
// - LIN auto-baud detects break after more than 11 dominant bits.
// - LIN sync must be 0x55, else mismatch flag and baud unchanged.
// - Count eight bit times; count/64 integer, remainder fraction, load baud.
// - Generic auto-baud skips sync check, loads only 0x0064 to 0xffff; code range-checks the tick count, not the value loaded.
// - Wait-for-break takes next fall then rise as a break.
// - One-wire mode loops transmit output into receiver.
// - Multiprocessor: type bit is stop1 or ninth bit; data dropped.
// - Comm mode 2 is infrared; pins inverted, double speed unavailable.
// - Infrared transmit: 3/16 bit, fixed clock count, or no modulation.
// - Infrared receive: high pulse under minimum width decodes as one.
// - Event channel as receive input disables receive pin.
// - SPI transfers start only on a transmit data write.
// - Shared interrupt raised by start, receive or auto-baud error flags.
module usm_core #(
  parameter int DATA_BITS = 8
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  // Configuration
  input  wire usm_pkg::usm_cfg_t     cfg,
  input  wire logic [15:0]           baud_wr_val,
  input  wire logic                  baud_wr,
  input  wire logic [7:0]            tx_pulse_len,
  input  wire logic [6:0]            rx_pulse_min,
  input  wire logic                  standby_sleep,
  input  wire logic                  other_wake,
  input  wire logic                  rx_complete_int_en,
  input  wire logic                  start_detect_int_en,
  input  wire logic                  autobaud_error_int_en,
  // Software strobes
  input  wire logic [8:0]            tx_data,
  input  wire logic                  tx_write,
  input  wire logic                  rx_read,
  input  wire logic                  flags_clear,
  input  wire logic                  wait_for_break_set,
  // Pins and event input
  input  wire logic                  rx_pin,
  input  wire logic                  ir_event_in,
  output logic                       tx_pin,
  output logic                       transfer_clock_pin,
  output logic                       tx_direction_out,
  // Status
  output usm_pkg::usm_rx_stat_t      rx_stat,
  output logic [15:0]                baud,
  output logic                       wait_for_break,
  output logic                       tx_busy,
  output logic                       osc_request,
  output logic                       sys_wake,
  output logic                       rx_irq
);
  import usm_pkg::*;

  // --------------------
  // Mode decode
  // --------------------
  logic spi_m, ir_m, autob, lin_m, sfd_act;
  assign spi_m   = (cfg.comm_mode_sel == USM_COMM_MODE_SEL_SPI);
  assign ir_m    = (cfg.comm_mode_sel == USM_COMM_MODE_SEL_IR);
  assign lin_m   = (cfg.receive_mode_sel == USM_RXM_LIN_AUTOBAUD_MODE);
  assign autob   = lin_m || (cfg.receive_mode_sel == USM_RXM_GENERIC_AUTOBAUD_MODE);
  assign sfd_act = cfg.start_detect_enable && standby_sleep
                   && (cfg.comm_mode_sel == USM_COMM_MODE_SEL_ASYNC);

  // Double speed ignored in infrared and SPI modes
  logic [4:0] os_len;
  assign os_len = (cfg.double_speed_sel && !ir_m && !spi_m) ? 5'd8 : 5'd16;

  // --------------------
  // Baud tick: integer part plus fractional accumulator
  // --------------------
  logic [9:0] bcnt;
  logic [6:0] facc;
  logic       tick;
  always_ff @(posedge clk) begin
    if (rst) begin
      bcnt <= '0;
      facc <= '0;
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= 1'b0;
      if (bcnt >= baud[15:6]) begin
        bcnt <= facc[6] ? 10'd1 : 10'd0;
        facc <= {1'b0, facc[5:0]} + {1'b0, baud[5:0]};
        tick <= 1'b1;
      end else begin
        bcnt <= bcnt + 10'd1;
      end
    end
  end

  // --------------------
  // Transmitter (sample ticks, os_len ticks per bit)
  // --------------------
  usm_tx_state_t tx_st;
  logic [8:0] tx_sh;
  logic [3:0] tx_bit;
  logic [4:0] tx_os;
  logic       tx_raw, sck;
  logic [4:0] nbits;
  assign nbits = cfg.nine_bit ? 5'd9 : DATA_BITS[4:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st <= USM_TX_IDLE;
      tx_sh <= '0;
      tx_bit <= '0;
      tx_os <= '0;
      tx_raw <= 1'b1;
      sck <= 1'b0;
    end else if (clk_en) begin
      case (tx_st)
        USM_TX_IDLE: begin
          if (tx_write && cfg.tx_en) begin
            tx_sh <= (spi_m && !cfg.spi_bit_order_sel) ?
                     {1'b0, tx_data[0], tx_data[1], tx_data[2], tx_data[3],
                      tx_data[4], tx_data[5], tx_data[6], tx_data[7]} : tx_data;
            tx_os <= '0;
            tx_bit <= '0;
            tx_st <= USM_TX_GUARD;
          end
        end
        USM_TX_GUARD: if (tick) begin
          tx_st <= spi_m ? USM_TX_DATA : USM_TX_START;
          tx_raw <= spi_m ? tx_sh[0] : 1'b0;
        end
        USM_TX_START: if (tick) begin
          tx_os <= tx_os + 5'd1;
          if (tx_os == os_len - 5'd1) begin
            tx_os <= '0;
            tx_raw <= tx_sh[0];
            tx_st <= USM_TX_DATA;
          end
        end
        USM_TX_DATA: if (tick) begin
          tx_os <= tx_os + 5'd1;
          // SPI clock: phase bit picks sample edge
          if (spi_m && tx_os == (os_len >> 1) - 5'd1)
            sck <= ~sck;
          if (tx_os == os_len - 5'd1) begin
            tx_os <= '0;
            if (spi_m) sck <= cfg.spi_clock_phase_sel;
            tx_sh <= {1'b1, tx_sh[8:1]};
            tx_raw <= tx_sh[1];
            tx_bit <= tx_bit + 4'd1;
            if (tx_bit == nbits[3:0] - 4'd1) begin
              tx_raw <= 1'b1;
              tx_st <= spi_m ? USM_TX_IDLE : USM_TX_STOP;
              if (spi_m) sck <= 1'b0;
            end
          end
        end
        USM_TX_STOP: if (tick) begin
          tx_os <= tx_os + 5'd1;
          if (tx_os == os_len - 5'd1) begin
            tx_os <= '0;
            tx_bit <= tx_bit + 4'd1;
            if (!cfg.two_stop || tx_bit == nbits[3:0] + 4'd1)
              tx_st <= USM_TX_IDLE;
          end
        end
        default: tx_st <= USM_TX_IDLE;
      endcase
    end
  end

  // Infrared pulse shaping on transmit: low bits become short pulses
  logic [7:0] ir_cnt;
  logic       ir_pulse;
  always_ff @(posedge clk) begin
    if (rst) begin
      ir_cnt <= '0;
    end else if (clk_en) begin
      if (tx_raw) ir_cnt <= '0;
      else if (ir_cnt != 8'hff) ir_cnt <= ir_cnt + 8'd1;
    end
  end
  always_comb begin
    case (cfg.ir_tx_mod)
      USM_IRTX_3_16: ir_pulse = !tx_raw && (tx_os < 5'(USM_IR_NUM));
      USM_IRTX_FIXED: ir_pulse = !tx_raw && (ir_cnt < tx_pulse_len);
      default: ir_pulse = !tx_raw;
    endcase
  end

  // Registered pin outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_pin <= 1'b1;
      transfer_clock_pin <= 1'b0;
      tx_direction_out <= 1'b0;
      tx_busy <= 1'b0;
    end else if (clk_en) begin
      tx_pin <= ir_m ? !ir_pulse : tx_raw;
      transfer_clock_pin <= spi_m && sck;
      tx_direction_out <= (cfg.line_driver_mode != USM_LD_OFF)
                          && (tx_st != USM_TX_IDLE);
      tx_busy <= (tx_st != USM_TX_IDLE);
    end
  end

  // --------------------
  // Receive input select and infrared decode
  // --------------------
  logic rx_src, rx_line;
  logic [4:0] rx_os;
  logic [6:0] hi_w;
  logic       ir_zero;
  assign rx_src = cfg.one_wire ? tx_pin :
                  (cfg.ir_event_sel ? ir_event_in : rx_pin);
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_w <= '0;
      ir_zero <= 1'b0;
    end else if (clk_en) begin
      // Pin level is inverse of pulse; pulse present while line low
      if (!rx_src) begin
        if (hi_w != 7'h7f) hi_w <= hi_w + 7'd1;
        if (hi_w >= rx_pulse_min) ir_zero <= 1'b1;
      end else begin
        hi_w <= '0;
      end
      if (tick && rx_os == os_len - 5'd1) ir_zero <= 1'b0;
    end
  end
  assign rx_line = ir_m ? !ir_zero : rx_src;

  // --------------------
  // Receiver, break detect and auto-baud
  // --------------------
  usm_rx_state_t rx_st;
  logic [3:0]  rx_bit;
  logic [8:0]  rx_sh;
  logic [15:0] low_run;
  logic [15:0] sync_cnt;
  logic        got_break, rx_prev, wfb_fell, mp_type;
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st <= USM_RX_IDLE;
      rx_os <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      low_run <= '0;
      sync_cnt <= '0;
      got_break <= 1'b0;
      rx_prev <= 1'b1;
      wfb_fell <= 1'b0;
      wait_for_break <= 1'b0;
      rx_stat <= '0;
      baud <= USM_BAUD_RESET;
    end else if (clk_en) begin
      rx_prev <= rx_line;
      if (baud_wr) baud <= baud_wr_val;
      if (wait_for_break_set) wait_for_break <= 1'b1;
      if (rx_read) rx_stat.rx_complete_flag <= 1'b0;
      if (spi_m) rx_stat.frame_err <= 1'b0;
      if (flags_clear) begin
        rx_stat.start_detect_flag <= 1'b0;
        rx_stat.sync_mismatch_flag <= 1'b0;
        rx_stat.break_flag <= 1'b0;
      end
      // Break by length of dominant run
      if (rx_line) low_run <= '0;
      else if (tick && low_run != 16'hffff) low_run <= low_run + 16'd1;
      if (autob && !wait_for_break && !got_break && tick
          && low_run == 16'(USM_BREAK_BITS) * {11'd0, os_len} + 16'd1) begin
        got_break <= 1'b1;
        rx_stat.break_flag <= 1'b1;
      end
      // Break by edge pair while waiting for break
      if (wait_for_break && rx_prev && !rx_line) wfb_fell <= 1'b1;
      if (wait_for_break && wfb_fell && !rx_prev && rx_line) begin
        wfb_fell <= 1'b0;
        wait_for_break <= 1'b0;
        got_break <= 1'b1;
        rx_stat.break_flag <= 1'b1;
        rx_st <= USM_RX_IDLE;
      end
      // Start-of-frame flag in standby
      if (sfd_act && rx_st == USM_RX_IDLE && rx_prev && !rx_line)
        rx_stat.start_detect_flag <= 1'b1;
      case (rx_st)
        USM_RX_IDLE: begin
          rx_os <= '0;
          rx_bit <= '0;
          sync_cnt <= '0;
          if (cfg.rx_en && rx_prev && !rx_line && !wait_for_break
              && (!autob || got_break || !low_run[15]))
            rx_st <= (autob && got_break) ? USM_RX_SYNC : USM_RX_START;
        end
        USM_RX_START: if (tick) begin
          rx_os <= rx_os + 5'd1;
          if (rx_os == (os_len >> 1) && rx_line) rx_st <= USM_RX_IDLE;
          if (rx_os == os_len - 5'd1) begin
            rx_os <= '0;
            rx_st <= USM_RX_DATA;
          end
        end
        USM_RX_DATA: if (tick) begin
          rx_os <= rx_os + 5'd1;
          if (rx_os == (os_len >> 1))
            rx_sh <= {rx_line, rx_sh[8:1]};
          if (rx_os == os_len - 5'd1) begin
            rx_os <= '0;
            rx_bit <= rx_bit + 4'd1;
            if (rx_bit == nbits[3:0] - 4'd1) rx_st <= USM_RX_STOP;
          end
        end
        USM_RX_STOP: if (tick) begin
          rx_os <= rx_os + 5'd1;
          if (rx_os == (os_len >> 1)) begin
            rx_st <= USM_RX_IDLE;
            // Frame type: ninth bit or first stop bit
            if (!cfg.multiproc_filter_en || mp_type) begin
              rx_stat.data <= cfg.nine_bit ? rx_sh :
                              (rx_sh >> (5'd9 - nbits));
              rx_stat.frame_err <= !spi_m && !rx_line;
              rx_stat.rx_complete_flag <= 1'b1;
            end
          end
        end
        USM_RX_SYNC: if (tick) begin
          // Count sample ticks over nine bit times (start plus eight) after sync start
          sync_cnt <= sync_cnt + 16'd1;
          if (sync_cnt == {11'd0, os_len} * 16'd9 - 16'd1) begin
            rx_st <= USM_RX_IDLE;
            got_break <= 1'b0;
            if (lin_m && rx_sh[7:0] != USM_SYNC_CHAR)
              rx_stat.sync_mismatch_flag <= 1'b1;
            else if (!lin_m && sync_cnt < USM_BAUD_MIN)
              rx_stat.sync_mismatch_flag <= 1'b1;
            else
              baud <= baud_from_count(sync_cnt);
          end
          if (sync_cnt[3:0] == 4'd7 && sync_cnt >= 16'd16)
            rx_sh <= {rx_line, rx_sh[8:1]};
        end
        default: rx_st <= USM_RX_IDLE;
      endcase
    end
  end
  assign mp_type = cfg.nine_bit ? rx_sh[8] : rx_line;

  // Eight measured bit times in sample ticks scaled to divider/64 form
  function automatic logic [15:0] baud_from_count(input logic [15:0] c);
    logic [15:0] r;
    logic [31:0] p;
    r = c - {11'd0, os_len};
    p = 32'(r) * 32'(baud);
    return p[22:7];
  endfunction : baud_from_count

  // --------------------
  // Sleep, wake and shared interrupt
  // --------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_request <= 1'b0;
      sys_wake <= 1'b0;
      rx_irq <= 1'b0;
    end else if (clk_en) begin
      osc_request <= (sfd_act && (rx_st != USM_RX_IDLE || !rx_line))
                     || (standby_sleep && rx_st != USM_RX_IDLE);
      sys_wake <= sfd_act && !other_wake &&
                  ((start_detect_int_en && rx_stat.start_detect_flag)
                   || (rx_complete_int_en && rx_stat.rx_complete_flag));
      rx_irq <= (rx_complete_int_en && rx_stat.rx_complete_flag)
                || (start_detect_int_en && rx_stat.start_detect_flag)
                || (autobaud_error_int_en && rx_stat.sync_mismatch_flag);
    end
  end

endmodule : usm_core

// File: usm_assertions.sv
`timescale 1ns/10ps
// --------------------
// Port checker
// --------------------
module usm_assertions
  import usm_pkg::*;
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  clk_en,
  // Controls
  input wire usm_pkg::usm_cfg_t     cfg,
  input wire logic                  baud_wr,
  input wire logic                  tx_write,
  input wire logic                  standby_sleep,
  input wire logic                  rx_complete_int_en,
  input wire logic                  start_detect_int_en,
  // Observed outputs
  input wire logic                  tx_pin,
  input wire logic                  transfer_clock_pin,
  input wire logic                  tx_direction_out,
  input wire usm_pkg::usm_rx_stat_t rx_stat,
  input wire logic [15:0]           baud,
  input wire logic                  tx_busy,
  input wire logic                  osc_request,
  input wire logic                  rx_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted transmit write, then direction up with the line still idle
  sequence tx_take_s;
    tx_write && !tx_busy && cfg.tx_en && clk_en;
  endsequence
  sequence tx_lead_s;
    tx_busy && tx_direction_out && tx_pin;
  endsequence
  wire ld_on = cfg.line_driver_mode != USM_LD_OFF && cfg.comm_mode_sel == USM_COMM_MODE_SEL_ASYNC;

  tx_take_a: assert property (tx_take_s |-> ##2 tx_busy)
    else $error("write not taken");
  dir_lead_a: assert property (tx_take_s ##0 ld_on |-> ##2 tx_lead_s)
    else $error("no direction lead");
  dir_start_a: assert property ($fell(tx_pin) && ld_on |-> $past(tx_direction_out))
    else $error("start before direction");
  dir_hold_a: assert property (tx_busy && ld_on |-> tx_direction_out)
    else $error("direction dropped");
  spi_err_a: assert property (cfg.comm_mode_sel == USM_COMM_MODE_SEL_SPI
    && $past(cfg.comm_mode_sel) == USM_COMM_MODE_SEL_SPI |-> !rx_stat.frame_err)
    else $error("spi frame error");
  spi_quiet_a: assert property (cfg.comm_mode_sel == USM_COMM_MODE_SEL_SPI
    && $past(cfg.comm_mode_sel) == USM_COMM_MODE_SEL_SPI && !tx_busy && !$past(tx_busy)
    |-> $stable(transfer_clock_pin)) else $error("spi clock moved");
  baud_upd_a: assert property ($changed(baud) && !$past(baud_wr)
    |-> cfg.receive_mode_sel != USM_RXM_NORMAL && baud >= USM_BAUD_MIN)
    else $error("bad baud update");
  mp_type_a: assert property ($rose(rx_stat.rx_complete_flag) && cfg.multiproc_filter_en
    && cfg.nine_bit |-> rx_stat.data[8]) else $error("data frame passed");
  sfd_sleep_a: assert property ($rose(rx_stat.start_detect_flag)
    |-> cfg.start_detect_enable && $past(standby_sleep)) else $error("start detect awake");
  irq_raise_a: assert property ((rx_stat.rx_complete_flag && rx_complete_int_en)
    || (rx_stat.start_detect_flag && start_detect_int_en) |-> ##[0:2] rx_irq)
    else $error("no receive irq");
  osc_wake_a: assert property ($rose(rx_stat.start_detect_flag) |-> ##[0:2] osc_request)
    else $error("no osc request");
endmodule : usm_assertions

bind usm_core usm_assertions chk_u (.clk(clk), .rst(rst), .clk_en(clk_en), .cfg(cfg),
  .baud_wr(baud_wr), .tx_write(tx_write), .standby_sleep(standby_sleep),
  .rx_complete_int_en(rx_complete_int_en), .start_detect_int_en(start_detect_int_en),
  .tx_pin(tx_pin), .transfer_clock_pin(transfer_clock_pin),
  .tx_direction_out(tx_direction_out), .rx_stat(rx_stat), .baud(baud), .tx_busy(tx_busy),
  .osc_request(osc_request), .rx_irq(rx_irq));

// File: usm_partner.sv
`timescale 1ns/10ps
// --------------------
// Remote serial node
// --------------------
module usm_partner (
  // Clock
  input  wire logic clk,
  // Serial lines
  input  wire logic line_in,
  input  wire logic sclk_in,
  output logic      line_out
);
  int bit_clks = 64;

  // Line rests at the pulled-up mark level
  initial line_out = 1'b1;

  // Drive one level for a number of bit times
  task automatic hold(input logic v, input int bits);
    line_out = v;
    repeat (bits * bit_clks) @(posedge clk);
    #1;
  endtask : hold

  // Dominant low for a number of bits, then a delimiter
  task automatic brk(input int bits);
    hold(1'b0, bits);
    hold(1'b1, 1);
  endtask : brk

  // Start bit, data lsb first, stop bits
  task automatic send(input logic [8:0] d, input int nb, input int nstop);
    hold(1'b0, 1);
    for (int i = 0; i < nb; i++) hold(d[i], 1);
    hold(1'b1, nstop);
  endtask : send

  // Wait for a start bit, then sample each bit at its centre
  task automatic recv(output logic [8:0] d, input int nb);
    int n;
    d = '0;
    for (n = 0; line_in && n < 200000; n++) @(posedge clk);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bit_clks) @(posedge clk);
      d[i] = line_in;
    end
    repeat (bit_clks) @(posedge clk);
  endtask : recv

  // Length of the first low period seen on the line
  task automatic measure(output int p);
    p = 0;
    while (line_in) @(posedge clk);
    while (!line_in) begin
      @(posedge clk);
      p++;
    end
  endtask : measure

  // Shift in eight bits on rising serial clock edges, first bit to the top
  task automatic spi_recv(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sclk_in);
      d[i] = line_in;
    end
  endtask : spi_recv
endmodule : usm_partner

// File: usart_special_modes_bench.sv
`timescale 1ns/10ps
module usart_special_modes_bench;
  import usm_pkg::*;
  // --------------------
  // Signals and reference state
  // --------------------
  logic clk, rst, baud_wr, standby_sleep, rx_complete_int_en, start_detect_int_en, clk_en;
  logic autobaud_error_int_en, tx_write, rx_read, flags_clear, wait_for_break_set;
  logic rx_pin, tx_pin, transfer_clock_pin, tx_direction_out, other_wake;
  logic wait_for_break, tx_busy, osc_request, sys_wake, rx_irq;
  logic [15:0] baud_wr_val, baud, b0;
  logic [8:0] tx_data, d, got;
  logic [7:0] g8;
  usm_cfg_t cfg;
  usm_rx_stat_t rx_stat;
  int failures = 0;
  int n_checks = 0;
  int per;
  int exp_q[$];

  usm_core dut_u (.clk(clk), .rst(rst), .clk_en(clk_en), .cfg(cfg), .baud_wr_val(baud_wr_val),
    .baud_wr(baud_wr), .tx_pulse_len(8'h04), .rx_pulse_min(7'h02), .standby_sleep(standby_sleep),
    .other_wake(other_wake), .rx_complete_int_en(rx_complete_int_en),
    .start_detect_int_en(start_detect_int_en), .autobaud_error_int_en(autobaud_error_int_en),
    .tx_data(tx_data), .tx_write(tx_write), .rx_read(rx_read), .flags_clear(flags_clear),
    .wait_for_break_set(wait_for_break_set), .rx_pin(rx_pin), .ir_event_in(1'b0),
    .tx_pin(tx_pin), .transfer_clock_pin(transfer_clock_pin),
    .tx_direction_out(tx_direction_out), .rx_stat(rx_stat), .baud(baud),
    .wait_for_break(wait_for_break), .tx_busy(tx_busy), .osc_request(osc_request),
    .sys_wake(sys_wake), .rx_irq(rx_irq));
  usm_partner peer_u (.clk(clk), .line_in(tx_pin), .sclk_in(transfer_clock_pin),
    .line_out(rx_pin));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // --------------------
  // Helpers
  // --------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse
  task automatic tx_idle();
    for (int n = 0; tx_busy && n < 100000; n++) step(1);
  endtask : tx_idle
  task automatic send_tx(input logic [8:0] v);
    tx_idle();
    tx_data = v;
    pulse(tx_write);
    step(1);
    if (cfg.line_driver_mode != USM_LD_OFF) begin
      chk(tx_direction_out, 1);
      chk(tx_pin, 1);
    end
  endtask : send_tx
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Watchdog
  initial begin
    step(60000);
    failures++;
    test_done();
  end

  // --------------------
  // Tests
  // --------------------
  initial begin
    cfg = '0;
    cfg.tx_en = 1'b1;
    cfg.rx_en = 1'b1;
    {baud_wr, standby_sleep, rx_complete_int_en, start_detect_int_en, tx_write} = '0;
    {autobaud_error_int_en, rx_read, flags_clear, wait_for_break_set, other_wake} = '0;
    clk_en = 1'b1;
    baud_wr_val = 16'h0100;
    tx_data = '0;
    rst = 1'b1;
    void'($urandom(32'h420d));
    step(10);
    rst = 1'b0;
    chk(tx_pin, 1);
    chk(tx_direction_out, 0);
    chk(baud, USM_BAUD_RESET);
    pulse(baud_wr);
    step(1);
    chk(baud, 16'h0100);
    $display("test reset done");
    // Bit time from a 0x55 frame, then both line-driver selections
    fork
      peer_u.measure(per);
      send_tx(9'h055);
    join
    tx_idle();
    peer_u.bit_clks = per;
    for (int m = 1; m <= 2; m++) begin
      cfg.line_driver_mode = 2'(m);
      repeat (2) begin
        d = 9'($urandom() % 256);
        exp_q.push_back(d);
        fork
          peer_u.recv(got, 8);
          send_tx(d);
        join
        tx_idle();
        chk(got, 16'(exp_q.pop_front()));
        chk(tx_direction_out, 0);
      end
    end
    $display("test line driver done");
    // Reception awake and in standby with start detection armed
    cfg.line_driver_mode = USM_LD_OFF;
    cfg.start_detect_enable = 1'b1;
    rx_complete_int_en = 1'b1;
    start_detect_int_en = 1'b1;
    for (int s = 0; s < 2; s++) begin
      standby_sleep = s[0];
      d = 9'($urandom() % 256);
      exp_q.push_back(d);
      peer_u.send(d, 8, 1);
      chk(rx_stat.data[7:0], 16'(exp_q.pop_front()));
      chk(rx_stat.start_detect_flag, s);
      chk(rx_irq, 1);
      chk(sys_wake, 16'(s));
      pulse(rx_read);
      pulse(flags_clear);
      step(2);
      chk(rx_irq, 0);
    end
    standby_sleep = 1'b0;
    cfg.start_detect_enable = 1'b0;
    $display("test start detect done");
    // One-wire loop: own transmission lands in the receiver
    cfg.one_wire = 1'b1;
    d = 9'($urandom() % 256);
    send_tx(d);
    tx_idle();
    step(4);
    chk(rx_stat.rx_complete_flag, 1);
    chk(rx_stat.data[7:0], d[7:0]);
    pulse(rx_read);
    cfg.one_wire = 1'b0;
    $display("test one wire done");
    // Address and data frames, type bit as ninth bit or first stop
    cfg.multiproc_filter_en = 1'b1;
    for (int nb = 0; nb < 2; nb++) begin
      cfg.nine_bit = nb[0];
      for (int t = 0; t < 2; t++) begin
        d = {t[0], 8'($urandom())};
        peer_u.send(d, 9, 1);
        step(2);
        chk(rx_stat.rx_complete_flag, t);
        pulse(rx_read);
      end
    end
    cfg.multiproc_filter_en = 1'b0;
    cfg.nine_bit = 1'b0;
    $display("test multiprocessor done");
    // Break with a wrong sync character, then wait-for-break
    cfg.receive_mode_sel = USM_RXM_LIN_AUTOBAUD_MODE;
    autobaud_error_int_en = 1'b1;
    b0 = baud;
    peer_u.brk(13);
    peer_u.send(9'h0aa, 8, 1);
    step(4);
    chk(rx_stat.break_flag, 1);
    chk(rx_stat.sync_mismatch_flag, 1);
    chk(baud, b0);
    chk(rx_irq, 1);
    pulse(flags_clear);
    pulse(rx_read);
    cfg.receive_mode_sel = USM_RXM_GENERIC_AUTOBAUD_MODE;
    pulse(wait_for_break_set);
    step(1);
    chk(wait_for_break, 1);
    peer_u.brk(1);
    peer_u.send(9'h055, 8, 1);
    step(4);
    chk(rx_stat.break_flag, 1);
    chk(baud >= USM_BAUD_MIN, 1);
    pulse(flags_clear);
    pulse(rx_read);
    $display("test auto baud done");
    // Master SPI in both bit orders
    cfg.receive_mode_sel = USM_RXM_NORMAL;
    cfg.comm_mode_sel = USM_COMM_MODE_SEL_SPI;
    for (int o = 0; o < 2; o++) begin
      cfg.spi_bit_order_sel = o[0];
      step(2);
      d = 9'($urandom() % 256);
      fork
        peer_u.spi_recv(g8);
        send_tx(d);
      join
      tx_idle();
      if (o == 1) g8 = {<<{g8}};
      chk(g8, d[7:0]);
      chk(rx_stat.frame_err, 0);
    end
    $display("test spi done");
    test_done();
  end
endmodule : usart_special_modes_bench
